// >>> hpb_buf_status.sv
`timescale 1ns/1ns
`default_nettype none
module hpb_buf_status (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// outside party
	input wire logic ext_wr,
	input wire logic ext_rd,
	input wire logic [1:0] ext_idx,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata,
	// software side
	input wire logic [3:0] sw_in_rd,
	input wire logic [3:0] sw_out_wr,
	input wire logic [7:0] sw_wdata,
	input wire logic clr_input_overflow_flag,
	input wire logic clr_output_underflow_flag,
	output wire logic [31:0] in_bytes,
	output wire logic [15:0] status
);
	wire logic [3:0] sel = 4'h1 << ext_idx;
	wire logic [3:0] in_full;
	wire logic [3:0] out_empty;
	wire logic [31:0] out_bytes;
	logic input_overflow_flag_q;
	logic output_underflow_flag_q;
	logic [7:0] rdata_q;
	wire logic ovf_ev = ext_wr & |(sel & in_full);
	wire logic unf_ev = ext_rd & |(sel & out_empty);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_slot
			logic full_q;
			logic empty_q;
			logic [7:0] ib_q;
			logic [7:0] ob_q;
			wire logic put = ext_wr & sel[g] & ~full_q;
			wire logic take = ext_rd & sel[g] & ~empty_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					full_q <= 1'b0;
					empty_q <= 1'b1;
					ib_q <= 8'h00;
					ob_q <= 8'h00;
				end else begin
					full_q <= put | (full_q & ~sw_in_rd[g]);
					empty_q <= take | (empty_q & ~sw_out_wr[g]);
					if (put)
						ib_q <= ext_wdata;
					if (sw_out_wr[g])
						ob_q <= sw_wdata;
				end
			end
			assign in_full[g] = full_q;
			assign out_empty[g] = empty_q;
			assign in_bytes[g*8 +: 8] = ib_q;
			assign out_bytes[g*8 +: 8] = ob_q;
		end
	endgenerate

	// set beats a clear landing in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_overflow_flag_q <= 1'b0;
			output_underflow_flag_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			input_overflow_flag_q <= ovf_ev | (input_overflow_flag_q & ~clr_input_overflow_flag);
			output_underflow_flag_q <= unf_ev | (output_underflow_flag_q & ~clr_output_underflow_flag);
			if (ext_rd)
				rdata_q <= out_bytes[{ext_idx, 3'b000} +: 8];
		end
	end

	assign ext_rdata = rdata_q;
	assign status = {&in_full, input_overflow_flag_q, 2'b00, in_full,
		&out_empty, output_underflow_flag_q, 2'b00, out_empty};
endmodule
`default_nettype wire

// >>> hpb_defines.svh
`ifndef HPB_DEFINES_SVH
`define HPB_DEFINES_SVH
// Behaviour
// - low two enables gate address pins 1-0
// - all-full flag while every input slot full
// - write to full slot sets sticky overflow
// - slot full flag clears on software read
// - all-empty flag while outputs empty, resets one
// - read of empty slot sets sticky underflow
// - slot empty flag clears on software write
// - master drives data, address, strobes; data only
// - width defaults eight bits, bit ten widens
// - chip selects share top two address pins
// - chip select field decodes 10, 01, 00
// - first chip select never enabled alone
// - strobe pin enables at bits nine, eight
// - enabled address pin drives address register bit
// - chip select inactive outside any transfer
// - low enables also gate latch strobes
// - mode one: direction line plus enable strobe
// - mode two: separate read, write strobes
// - polarity bit per signal, one means high; both latch strobes share bit 5
// - shared pin uses one polarity bit
// - multiplex field selects four address modes
// - top enables give address or chip select

// ==========================================
// register byte offsets
`define HPB_OFF_CON 8'h00
`define HPB_OFF_MODE 8'h04
`define HPB_OFF_ADDR 8'h08
`define HPB_OFF_PIN_FUNCTION_ENABLE 8'h0c
`define HPB_OFF_STAT 8'h10
`define HPB_OFF_CMD 8'h14
`define HPB_OFF_DATA 8'h18
`define HPB_OFF_INB 8'h20
`define HPB_OFF_OUTB 8'h30

// ==========================================
// field positions
`define HPB_CON_MUX 11
`define HPB_CON_WREN 9
`define HPB_CON_RDEN 8
`define HPB_CON_CSF 6
`define HPB_CON_ALP 5
`define HPB_CON_SECOND_SELECT_POLARITY 4
`define HPB_CON_FIRST_SELECT_POLARITY 3
`define HPB_CON_WRITE_POLARITY 1
`define HPB_CON_READ_POLARITY 0
`define HPB_CON_MASK 16'h1bfb
`define HPB_MODE_BUSY 15
`define HPB_MODE_WIDE 10
`define HPB_MODE_MM 8
`define HPB_ST_INPUT_OVERFLOW_FLAG 14
`define HPB_ST_OUTPUT_UNDERFLOW_FLAG 6
`define HPB_CMD_GO 0
`define HPB_CMD_RD 1

// ==========================================
// encodings and reset values
`define HPB_MUX_DEMUX 2'b00
`define HPB_MUX_PART 2'b01
`define HPB_MUX_FULL8 2'b10
`define HPB_MUX_FULL16 2'b11
`define HPB_CSF_BOTH 2'b10
`define HPB_CSF_SECOND 2'b01
`define HPB_MM_ONE 2'b01
`define HPB_MM_RST 2'b10
`endif

// >>> hpb_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
module hpb_ext_mem (
	// clock
	input wire logic pclk,
	// bus at the pins
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic rd_act,
	input wire logic wr_act,
	output logic [15:0] rdata
);
	logic [15:0] mem [16];
	logic [15:0] junk_q = 16'h5a3c;
	always_ff @(posedge pclk) begin
		junk_q <= ~junk_q;
		if (wr_act) begin
			mem[addr] <= wdata;
		end
	end
	// released bus toggles so a late sample shows up
	assign rdata = rd_act ? mem[addr] : junk_q;
endmodule
`default_nettype wire

// >>> hpb_pkg.sv
`default_nettype none
package hpb_pkg;
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_all = 4'b0010,
		st_alh = 4'b0100,
		st_stb = 4'b1000
	} hpb_state_e;

	typedef struct packed {
		logic [1:0] addr_data_multiplex_field;
		logic [1:0] chip_select_function_field;
		logic [1:0] mm;
		logic wide;
		logic latch_strobe_polarity;
		logic second_select_polarity;
		logic first_select_polarity;
		logic write_polarity;
		logic read_polarity;
	} hpb_cfg_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic all;
		logic alh;
		logic cs1;
		logic cs2;
	} hpb_ctl_s;
endpackage
`default_nettype wire

// >>> hpb_strobe_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "hpb_defines.svh"
module hpb_strobe_gen (
	// configuration and sequence state
	input wire hpb_pkg::hpb_cfg_s cfg,
	input wire hpb_pkg::hpb_state_e state,
	input wire logic rd_xfer,
	input wire logic cs1_sel,
	input wire logic cs2_sel,
	// pin levels
	output var hpb_pkg::hpb_ctl_s ctl
);
	function automatic logic pol(input logic p, input logic act);
		pol = p ? act : ~act;
	endfunction

	wire logic busy = state != hpb_pkg::st_idle;
	wire logic stb = state == hpb_pkg::st_stb;
	wire logic mode1 = cfg.mm == `HPB_MM_ONE;
	wire logic all_act = state == hpb_pkg::st_all;
	wire logic full16 = cfg.addr_data_multiplex_field == `HPB_MUX_FULL16;
	wire logic alh_act = (state == hpb_pkg::st_alh) | (all_act & full16);
	// mode one: read pin is direction for the whole transfer
	wire logic rd_act = mode1 ? (busy & rd_xfer) : (stb & rd_xfer);
	wire logic wr_act = mode1 ? stb : (stb & ~rd_xfer);

	assign ctl.rd = pol(cfg.read_polarity, rd_act);
	assign ctl.wr = pol(cfg.write_polarity, wr_act);
	assign ctl.all = pol(cfg.latch_strobe_polarity, all_act);
	assign ctl.alh = pol(cfg.latch_strobe_polarity, alh_act);
	assign ctl.cs1 = pol(cfg.first_select_polarity, busy & cs1_sel);
	assign ctl.cs2 = pol(cfg.second_select_polarity, busy & cs2_sel);
endmodule
`default_nettype wire

// >>> hpb_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, read_strobe_o, read_strobe_oe, write_strobe_o, write_strobe_oe;
	logic [15:0] addr_pin_o, addr_pin_oe, data_pin_i, data_pin_o, data_pin_oe;
	logic ext_wr = 1'b0, ext_rd = 1'b0;
	logic [1:0] ext_idx = 2'h0;
	logic [7:0] ext_wdata = 8'h00, ext_rdata;
	logic [15:0] cfg_t = 16'h03b8;
	logic [1:0] mm_t = 2'h2;
	int err_total = 0, checks_done = 0;
	wire logic rd_on = read_strobe_oe && (read_strobe_o == cfg_t[0]);
	wire logic wr_on = write_strobe_oe && (write_strobe_o == cfg_t[1]);
	wire logic md1 = mm_t == 2'h1;
	always #5 pclk = ~pclk;
	hpb_top hpb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe),
		.data_pin_i(data_pin_i), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe),
		.read_strobe_o(read_strobe_o), .read_strobe_oe(read_strobe_oe),
		.write_strobe_o(write_strobe_o), .write_strobe_oe(write_strobe_oe), .ext_wr(ext_wr),
		.ext_rd(ext_rd), .ext_idx(ext_idx), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
	hpb_ext_mem hpb_ext_mem_i (.pclk(pclk), .addr(addr_pin_o[3:0]), .wdata(data_pin_o),
		.rd_act(md1 ? (wr_on && rd_on) : rd_on), .wr_act(md1 ? (wr_on && !rd_on) : wr_on),
		.rdata(data_pin_i));
	// ====
	// bus tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(q, x)
	endtask
	task automatic ext(input logic w, input logic [1:0] i, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge pclk);
		ext_wr <= w;
		ext_rd <= !w;
		ext_idx <= i;
		ext_wdata <= d;
		@(posedge pclk);
		ext_wr <= 1'b0;
		ext_rd <= 1'b0;
		@(negedge pclk);
		q = ext_rdata;
	endtask
	task automatic go(input logic [31:0] c);
		logic [31:0] q;
		logic e;
		wr(8'h14, c);
		for (int n = 0; n < 20; n++) begin
			apb(1'b0, 8'h04, 32'h0, q, e);
			if (q[15] === 1'b0) break;
		end
		`CHK(q[15], 1'b0)
	endtask
	// ====
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		`CHK(addr_pin_oe, 16'h0000)
		`CHK(pready, 1'b1)
		rd_chk(8'h10, 32'h0000008f);
		rd_chk(8'h04, 32'h00000200);
		apb(1'b0, 8'h1c, 32'h0, q, e);
		`CHK(e, 1'b1)
	endtask
	task automatic t_slave();
		logic [7:0] q;
		for (int i = 0; i < 4; i++) ext(1'b1, i[1:0], 8'h10 + 8'(i), q);
		rd_chk(8'h10, 32'h00008f8f);
		ext(1'b1, 2'h0, 8'h77, q);
		rd_chk(8'h10, 32'h0000cf8f);
		rd_chk(8'h20, 32'h00000010);
		rd_chk(8'h10, 32'h00004e8f);
		wr(8'h10, 32'h0);
		rd_chk(8'h10, 32'h00000e8f);
		ext(1'b0, 2'h2, 8'h00, q);
		rd_chk(8'h10, 32'h00000ecf);
		wr(8'h34, 32'h0000005a);
		rd_chk(8'h10, 32'h00000e4d);
		ext(1'b0, 2'h1, 8'h00, q);
		`CHK(q, 8'h5a)
		wr(8'h10, 32'h0000ffff);
		rd_chk(8'h10, 32'h00000ecf);
	endtask
	task automatic t_link();
		wr(8'h0c, 32'h0000fffc);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		`CHK(addr_pin_oe, 16'hfffc)
		wr(8'h0c, 32'h0000ffff);
		wr(8'h00, 32'h000003b8);
		wr(8'h04, 32'h00000600);
		wr(8'h08, 32'h0000c005);
		wr(8'h18, 32'h0000beef);
		go(32'h1);
		wr(8'h18, 32'h0);
		go(32'h3);
		rd_chk(8'h18, 32'h0000beef);
		// strobes parked while mode changes, polarity set in the write that re-enables them, no stray strobe
		wr(8'h00, 32'h000000b8);
		wr(8'h04, 32'h00000500);
		wr(8'h00, 32'h000003bb);
		cfg_t <= 16'h03bb;
		mm_t <= 2'h1;
		wr(8'h18, 32'h00001234);
		go(32'h1);
		wr(8'h18, 32'h0);
		go(32'h3);
		rd_chk(8'h18, 32'h00001234);
	endtask
	task automatic t_csf();
		logic [1:0] x;
		for (int c = 0; c < 4; c++) begin
			x = (c == 2) ? 2'b00 : (c == 1) ? 2'b01 : 2'b11;
			wr(8'h00, 32'h0000033b | (c << 6));
			repeat (2) @(posedge pclk);
			@(negedge pclk);
			`CHK(addr_pin_o, {x, 14'h0005})
		end
	endtask
	task automatic t_mux();
		wr(8'h04, 32'h00000600);
		mm_t <= 2'h2;
		for (int m = 1; m < 4; m++) begin
			wr(8'h00, 32'h000003bb | (m << 11));
			wr(8'h18, 32'h000000a0 + m);
			go(32'h1);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_slave();
		t_link();
		t_csf();
		t_mux();
		complete_run();
	end
	initial begin
		#50000;
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire

// >>> hpb_top.sv
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "hpb_defines.svh"
module hpb_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// address and chip select pins
	output logic [15:0] addr_pin_o,
	output logic [15:0] addr_pin_oe,
	// data pins
	input wire logic [15:0] data_pin_i,
	output logic [15:0] data_pin_o,
	output logic [15:0] data_pin_oe,
	// strobe pins
	output logic read_strobe_o,
	output logic read_strobe_oe,
	output logic write_strobe_o,
	output logic write_strobe_oe,
	// slave buffer access by outside party
	input wire logic ext_wr,
	input wire logic ext_rd,
	input wire logic [1:0] ext_idx,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata
);
	// ==========================================
	// decode helpers
	function automatic logic [3:0] slot_sel(
		input logic [7:0] a,
		input logic [7:0] base
	);
		slot_sel = 4'h0;
		if (a[7:4] == base[7:4] && a[1:0] == 2'b00)
			slot_sel = 4'h1 << a[3:2];
	endfunction

	// ==========================================
	// registers and state
	logic [15:0] con_q;
	logic [2:0] mode_q;
	logic [15:0] addr_q;
	logic [15:0] pin_function_enable_q;
	logic [15:0] wdat_q;
	logic [15:0] rdat_q;
	logic rd_xfer_q;
	logic pend_q;
	logic [31:0] prdata_q;
	hpb_pkg::hpb_state_e state_q;
	hpb_pkg::hpb_state_e state_d;
	hpb_pkg::hpb_cfg_s cfg;
	hpb_pkg::hpb_ctl_s ctl;
	logic [15:0] apin_q;
	logic [15:0] aoe_q;
	logic [15:0] dpin_q;
	logic [15:0] doe_q;
	logic rd_pin_q;
	logic wr_pin_q;
	logic rd_oe_q;
	logic wr_oe_q;
	wire logic [15:0] apin_d;
	wire logic [15:0] aoe_d;
	wire logic [31:0] in_bytes;
	wire logic [15:0] status;

	// ==========================================
	// apb decode
	wire logic setup = psel & ~penable;
	wire logic access = psel & penable;
	wire logic wr_acc = access & pwrite;
	wire logic rd_acc = access & ~pwrite;
	wire logic hit_con = paddr == `HPB_OFF_CON;
	wire logic hit_mode = paddr == `HPB_OFF_MODE;
	wire logic hit_addr = paddr == `HPB_OFF_ADDR;
	wire logic hit_pin_function_enable = paddr == `HPB_OFF_PIN_FUNCTION_ENABLE;
	wire logic hit_stat = paddr == `HPB_OFF_STAT;
	wire logic hit_cmd = paddr == `HPB_OFF_CMD;
	wire logic hit_data = paddr == `HPB_OFF_DATA;
	wire logic [3:0] in_hit = slot_sel(paddr, `HPB_OFF_INB);
	wire logic [3:0] out_hit = slot_sel(paddr, `HPB_OFF_OUTB);
	wire logic hit_any = hit_con | hit_mode | hit_addr | hit_pin_function_enable
		| hit_stat | hit_cmd | hit_data | (|in_hit) | (|out_hit);
	wire logic idle = state_q == hpb_pkg::st_idle;
	wire logic busy = ~idle | pend_q;
	// a start while busy is dropped rather than queued
	wire logic start = wr_acc & hit_cmd & pwdata[`HPB_CMD_GO] & ~busy;
	wire logic [7:0] in_byte = in_bytes[{paddr[3:2], 3'b000} +: 8];
	wire logic [31:0] mode_rd = {16'h0000, busy, 4'h0, mode_q, 8'h00};
	wire logic [31:0] rd_word =
		hit_con ? {16'h0000, con_q} :
		hit_mode ? mode_rd :
		hit_addr ? {16'h0000, addr_q} :
		hit_pin_function_enable ? {16'h0000, pin_function_enable_q} :
		hit_stat ? {16'h0000, status} :
		hit_data ? {16'h0000, rdat_q} :
		(|in_hit) ? {24'h000000, in_byte} :
		32'h00000000;

	assign pready = 1'b1;
	assign pslverr = access & ~hit_any;
	assign prdata = prdata_q;

	// ==========================================
	// configuration view
	assign cfg.addr_data_multiplex_field = con_q[`HPB_CON_MUX +: 2];
	assign cfg.chip_select_function_field = con_q[`HPB_CON_CSF +: 2];
	assign cfg.latch_strobe_polarity = con_q[`HPB_CON_ALP];
	assign cfg.second_select_polarity = con_q[`HPB_CON_SECOND_SELECT_POLARITY];
	assign cfg.first_select_polarity = con_q[`HPB_CON_FIRST_SELECT_POLARITY];
	assign cfg.write_polarity = con_q[`HPB_CON_WRITE_POLARITY];
	assign cfg.read_polarity = con_q[`HPB_CON_READ_POLARITY];
	assign cfg.wide = mode_q[2];
	assign cfg.mm = mode_q[1:0];

	// field value 11 falls back to plain address on both pins
	wire logic cs1_en = cfg.chip_select_function_field == `HPB_CSF_BOTH;
	wire logic cs2_en = cs1_en | (cfg.chip_select_function_field == `HPB_CSF_SECOND);
	wire logic demux = cfg.addr_data_multiplex_field == `HPB_MUX_DEMUX;
	wire logic part = cfg.addr_data_multiplex_field == `HPB_MUX_PART;
	wire logic full16 = cfg.addr_data_multiplex_field == `HPB_MUX_FULL16;
	// chip select pins drop out of the bus address
	wire logic [15:0] ea = {addr_q[15] & ~cs2_en, addr_q[14] & ~cs1_en,
		addr_q[13:0]};

	// ==========================================
	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con_q <= 16'h0000;
			mode_q <= {1'b0, `HPB_MM_RST};
			addr_q <= 16'h0000;
			pin_function_enable_q <= 16'h0000;
			wdat_q <= 16'h0000;
			rd_xfer_q <= 1'b0;
		end else begin
			if (wr_acc && hit_con)
				con_q <= pwdata[15:0] & `HPB_CON_MASK;
			if (wr_acc && hit_mode)
				mode_q <= {pwdata[`HPB_MODE_WIDE], pwdata[`HPB_MODE_MM +: 2]};
			if (wr_acc && hit_addr)
				addr_q <= pwdata[15:0];
			if (wr_acc && hit_pin_function_enable)
				pin_function_enable_q <= pwdata[15:0];
			if (wr_acc && hit_data)
				wdat_q <= pwdata[15:0];
			if (start)
				rd_xfer_q <= pwdata[`HPB_CMD_RD];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (setup && !pwrite)
			prdata_q <= rd_word;
	end

	// ==========================================
	// transfer sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			hpb_pkg::st_idle: begin
				if (start)
					state_d = demux ? hpb_pkg::st_stb : hpb_pkg::st_all;
			end
			hpb_pkg::st_all: begin
				if (cfg.addr_data_multiplex_field == `HPB_MUX_FULL8)
					state_d = hpb_pkg::st_alh;
				else
					state_d = hpb_pkg::st_stb;
			end
			hpb_pkg::st_alh: begin
				state_d = hpb_pkg::st_stb;
			end
			hpb_pkg::st_stb: begin
				state_d = hpb_pkg::st_idle;
			end
		endcase
	end

	wire logic in_all = state_q == hpb_pkg::st_all;
	wire logic in_alh = state_q == hpb_pkg::st_alh;
	wire logic in_stb = state_q == hpb_pkg::st_stb;
	wire logic wr_stb = in_stb & ~rd_xfer_q;

	// pins lag the state by one edge, so read data is taken
	// at the edge that closes the registered strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= hpb_pkg::st_idle;
			pend_q <= 1'b0;
			rdat_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			pend_q <= in_stb & rd_xfer_q;
			if (pend_q)
				rdat_q <= cfg.wide ? data_pin_i : {8'h00, data_pin_i[7:0]};
		end
	end

	hpb_strobe_gen u_strobe (
		.cfg(cfg),
		.state(state_q),
		.rd_xfer(rd_xfer_q),
		.cs1_sel(addr_q[15 - 1]),
		.cs2_sel(addr_q[15]),
		.ctl(ctl)
	);

	// ==========================================
	// address pin functions
	genvar k;
	generate
		for (k = 0; k < 16; k++) begin : g_apin
			if (k < 2) begin : g_latch
				wire logic strobe = (k == 0) ? ctl.all : ctl.alh;
				assign apin_d[k] = demux ? addr_q[k] : strobe;
				assign aoe_d[k] = pin_function_enable_q[k] & ((k == 0) | ~part);
			end else if (k < 14) begin : g_addr
				assign apin_d[k] = addr_q[k];
				assign aoe_d[k] = pin_function_enable_q[k] & (demux | (part & (k >= 8)));
			end else begin : g_cs
				wire logic cs_on = (k == 14) ? cs1_en : cs2_en;
				wire logic cs_lvl = (k == 14) ? ctl.cs1 : ctl.cs2;
				assign apin_d[k] = cs_on ? cs_lvl : addr_q[k];
				assign aoe_d[k] = pin_function_enable_q[k] & (cs_on | demux | part);
			end
		end
	endgenerate

	// ==========================================
	// data pin functions
	wire logic [7:0] dlo_d = in_all ? ea[7:0] : in_alh ? ea[15:8] : wdat_q[7:0];
	wire logic [7:0] dhi_d = (in_all & full16) ? ea[15:8] : wdat_q[15:8];
	wire logic dlo_oe = in_all | in_alh | wr_stb;
	wire logic dhi_oe = cfg.wide & ((in_all & full16) | wr_stb);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apin_q <= 16'h0000;
			aoe_q <= 16'h0000;
			dpin_q <= 16'h0000;
			doe_q <= 16'h0000;
		end else begin
			apin_q <= apin_d;
			aoe_q <= aoe_d;
			dpin_q <= {dhi_d, dlo_d};
			doe_q <= {{8{dhi_oe}}, {8{dlo_oe}}};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pin_q <= 1'b0;
			wr_pin_q <= 1'b0;
			rd_oe_q <= 1'b0;
			wr_oe_q <= 1'b0;
		end else begin
			rd_pin_q <= ctl.rd;
			wr_pin_q <= ctl.wr;
			rd_oe_q <= con_q[`HPB_CON_RDEN];
			wr_oe_q <= con_q[`HPB_CON_WREN];
		end
	end

	assign addr_pin_o = apin_q;
	assign addr_pin_oe = aoe_q;
	assign data_pin_o = dpin_q;
	assign data_pin_oe = doe_q;
	assign read_strobe_o = rd_pin_q;
	assign read_strobe_oe = rd_oe_q;
	assign write_strobe_o = wr_pin_q;
	assign write_strobe_oe = wr_oe_q;

	// ==========================================
	// slave buffers and status
	wire logic stat_wr = wr_acc & hit_stat;

	hpb_buf_status u_status (
		.pclk(pclk),
		.presetn(presetn),
		.ext_wr(ext_wr),
		.ext_rd(ext_rd),
		.ext_idx(ext_idx),
		.ext_wdata(ext_wdata),
		.ext_rdata(ext_rdata),
		.sw_in_rd(in_hit & {4{rd_acc}}),
		.sw_out_wr(out_hit & {4{wr_acc}}),
		.sw_wdata(pwdata[7:0]),
		.clr_input_overflow_flag(stat_wr & ~pwdata[`HPB_ST_INPUT_OVERFLOW_FLAG]),
		.clr_output_underflow_flag(stat_wr & ~pwdata[`HPB_ST_OUTPUT_UNDERFLOW_FLAG]),
		.in_bytes(in_bytes),
		.status(status)
	);
endmodule
`default_nettype wire

// >>> hpb_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module hpb_top_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	// pins
	input wire logic [15:0] addr_pin_o,
	input wire logic [15:0] addr_pin_oe,
	input wire logic [15:0] data_pin_o,
	input wire logic [15:0] data_pin_oe,
	input wire logic read_strobe_oe,
	input wire logic write_strobe_o,
	input wire logic write_strobe_oe
);
	// ====
	// shadow settings; _l copies lag one more edge to match registered pins
	logic [15:0] con_q, con_l, dat_q;
	logic [2:0] mode_q, mode_l;
	logic [3:0] since_q;
	wire logic apb_wr = psel && penable && pwrite;
	wire logic map_ok = (paddr[1:0] == 2'h0)
		&& (paddr[7:2] < 6'h07 || paddr[7:4] == 4'h2 || paddr[7:4] == 4'h3);
	wire logic wr_act = write_strobe_oe && (write_strobe_o == con_l[1]);
	wire logic mux_on = con_l[12:11] != 2'h0;
	wire logic lo_act = addr_pin_oe[0] && (addr_pin_o[0] == con_l[5]) && mux_on;
	wire logic hi_act = addr_pin_oe[1] && (addr_pin_o[1] == con_l[5]) && mux_on;
	wire logic cs2_on = addr_pin_oe[15] && (addr_pin_o[15] == con_l[4])
		&& (con_l[7:6] == 2'h2 || con_l[7:6] == 2'h1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con_q <= 16'h0000;
			con_l <= 16'h0000;
			dat_q <= 16'h0000;
			mode_q <= 3'h2;
			mode_l <= 3'h2;
			since_q <= 4'hf;
		end else begin
			con_l <= con_q;
			mode_l <= mode_q;
			con_q <= (apb_wr && paddr == 8'h00) ? pwdata[15:0] : con_q;
			mode_q <= (apb_wr && paddr == 8'h04) ? pwdata[10:8] : mode_q;
			dat_q <= (apb_wr && paddr == 8'h18) ? pwdata[15:0] : dat_q;
			// saturates, so a long idle never wraps into a false pass
			since_q <= (apb_wr && (paddr == 8'h00 || paddr == 8'h14)) ? 4'h0 :
				(since_q == 4'hf) ? since_q : since_q + 4'h1;
		end
	end
	// ====
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_full8;
		lo_act && !hi_act ##1 hi_act && !lo_act;
	endsequence
	sequence s_wr_rise;
		!wr_act ##1 wr_act;
	endsequence
	chk_slverr_map: assert property (psel && penable |-> pslverr == !map_ok)
		else $error("slverr wrong");
	chk_strobe_pin_en: assert property (apb_wr && paddr == 8'h00 |->
		##2 {write_strobe_oe, read_strobe_oe} == con_l[9:8]) else $error("strobe enable");
	chk_addr_pin_en: assert property (apb_wr && paddr == 8'h0c && con_q[12:11] == 2'h0 |->
		##2 addr_pin_oe == $past(pwdata[15:0], 2)) else $error("addr enable");
	chk_cs_idle: assert property (cs2_on |-> since_q < 4'h8)
		else $error("chip select idle");
	chk_wr_pulse: assert property (s_wr_rise |=> !wr_act)
		else $error("write pulse");
	chk_narrow_upper: assert property (!mode_l[2] |-> data_pin_oe[15:8] == 8'h00)
		else $error("upper data driven");
	chk_wr_data: assert property (wr_act && mode_l[1:0] != 2'h1 |->
		data_pin_oe[7:0] == 8'hff && data_pin_o[7:0] == dat_q[7:0]) else $error("write data");
	chk_latch_full8: assert property ($rose(lo_act) && con_l[12:11] == 2'h2 |-> s_full8)
		else $error("latch order");
	chk_latch_full16: assert property (lo_act && con_l[12:11] == 2'h3 |-> hi_act)
		else $error("latch pair");
endmodule
bind hpb_top hpb_top_props hpb_top_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe), .data_pin_o(data_pin_o),
	.data_pin_oe(data_pin_oe), .read_strobe_oe(read_strobe_oe),
	.write_strobe_o(write_strobe_o), .write_strobe_oe(write_strobe_oe));
`default_nettype wire
